// File: design/sicu_defs.svh
// What this block does
// - Codes 00000 to 00111 are immediate commands
// - Codes 01000 to 10101 are interrupt commands
// - Chip reset clears everything like hard reset
// - Disconnect releases all bus lines at once
// - Timeout disconnect ignores former target's reselection
// - Disconnect while disconnected is ignored
// - Pause valid as target or disconnected only
// - Target pause aborts transfer, sets paused flag
// - Paused transfer keeps counter for resume
// - Pause before arbitration won: abandon, flag
// - Pause after arbitration: drop IDs, hold select
// - Idle pause sets paused flag immediately
// - Pause interrupts only as target with ATN; interrupts take precedence
// - Target pause with ATN raises bus service
// - Set attention only as initiator, immediately
// - Message out drops ATN at count end
// - ATN on select-with-attention win, parity error
// - Message accepted, initiator only, releases ACK
// - Last message-in byte: function complete, hold ACK
// - Immediate commands act within three clocks
// - Interrupt clears command register; immediates unstored
`ifndef SICU_DEFS_SVH
`define SICU_DEFS_SVH

// ************************************************************
// Command register layout and codes
// ************************************************************
`define SICU_CODE_MSB 4
`define SICU_CMD_RST_VAL 8'h00
`define SICU_IMM_LAST 5'h07
`define SICU_INT_FIRST 5'h08
`define SICU_INT_LAST 5'h15
`define SICU_C_CHIP_RESET 5'h00
`define SICU_C_DISCONNECT 5'h01
`define SICU_C_PAUSE 5'h02
`define SICU_C_SET_ATN 5'h03
`define SICU_C_MSG_ACCEPT 5'h04
`define SICU_C_CHIP_DISABLE 5'h05

// ************************************************************
// Status bit positions
// ************************************************************
`define SICU_ASR_PS_BIT 2
`define SICU_IR_FNC_BIT 0
`define SICU_IR_BUS_BIT 1
`define SICU_STAT_RST_VAL 8'h00
`define SICU_ID_OFF 2'b00

// ************************************************************
// Bus pin input indices
// ************************************************************
`define SICU_PIN_ATN 0
`define SICU_PIN_BSY 1
`define SICU_PIN_IO 2
`define SICU_PIN_MSG 3
`define SICU_PIN_CD 4
`define SICU_PIN_NUM 5

// ************************************************************
// Timing
// ************************************************************
`define SICU_CLK_KHZ 20000
`define SICU_SEL_HOLD_US 100
`define SICU_SEL_HOLD_CYC ((`SICU_SEL_HOLD_US * `SICU_CLK_KHZ + 999) / 1000)
`define SICU_HOLD_W 12

`endif

// File: design/sicu_pkg.sv
package sicu_pkg;

   typedef enum logic [1:0] {
      ROLE_DIS,
      ROLE_INIT,
      ROLE_TARG
   } sicu_role_e;

   typedef enum logic [1:0] {
      PS_IDLE,
      PS_XFER,
      PS_HOLD,
      PS_BSY
   } sicu_pause_e;

   // Status and requests from the bus sequencer, same clock
   typedef struct packed {
      sicu_role_e role;
      logic sel_pending;
      logic arb_won;
      logic xfer_active;
      logic byte_done;
      logic msg_out_phase;
      logic tc_zero;
      logic sbt_byte_done;
      logic parity_err;
      logic selatn_won;
      logic last_in_byte;
      logic intr_event;
      logic timeout_disc;
      logic ack_req;
      logic sel_req;
      logic [1:0] id_req;
   } sicu_seq_s;

   // Orders to the bus sequencer
   typedef struct packed {
      logic int_go;
      logic chip_reset;
      logic disconnect;
      logic abort_xfer;
      logic abort_sel;
      logic ignore_target;
   } sicu_ctl_s;

   // Driven open-drain bus lines, one flag per line
   typedef struct packed {
      logic atn;
      logic ack;
      logic sel;
      logic [1:0] id;
   } sicu_pins_s;

endpackage : sicu_pkg

// File: design/sicu_cmd_unit.sv
`timescale 1ns/1ps
`include "sicu_defs.svh"

module sicu_cmd_unit
   import sicu_pkg::*;
#(
   parameter int unsigned SEL_HOLD_CYC = `SICU_SEL_HOLD_CYC
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic cmd_wr_in,
   input wire logic [7:0] wdata_in,
   input wire logic ir_rd_in,
   input wire sicu_seq_s seq_in,
   input wire logic [`SICU_PIN_NUM-1:0] bus_n_in,
   output logic [7:0] command_register_out,
   output logic [7:0] auxiliary_status_register_out,
   output logic [7:0] interrupt_register_out,
   output sicu_ctl_s ctl_out,
   output sicu_pins_s bus_n_out,
   output sicu_pins_s bus_oe_out
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [`SICU_PIN_NUM-1:0] s1_q;
   logic [`SICU_PIN_NUM-1:0] s2_q;
   logic [`SICU_PIN_NUM-1:0] s3_q;
   logic [`SICU_PIN_NUM-1:0] filt_q;

   genvar gi;
   generate
      for (gi = 0; gi < `SICU_PIN_NUM; gi++) begin : g_sync
         always_ff @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
               s1_q[gi] <= 1'b1;
               s2_q[gi] <= 1'b1;
               s3_q[gi] <= 1'b1;
               filt_q[gi] <= 1'b1;
            end else begin
               s1_q[gi] <= bus_n_in[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               // Glitch of one sample is not taken
               if (s2_q[gi] == s3_q[gi]) begin
                  filt_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   // Lines are active low
   wire atn_on = ~filt_q[`SICU_PIN_ATN];
   wire bsy_on = ~filt_q[`SICU_PIN_BSY];
   wire msgin_phase = ~filt_q[`SICU_PIN_IO] & ~filt_q[`SICU_PIN_MSG] & ~filt_q[`SICU_PIN_CD];

   // ************************************************************
   // Command capture and decode
   // ************************************************************
   logic wr_q;
   logic [7:0] wdat_q;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_q <= 1'b0;
         wdat_q <= `SICU_CMD_RST_VAL;
      end else begin
         wr_q <= cmd_wr_in;
         wdat_q <= wdata_in;
      end
   end

   wire [`SICU_CODE_MSB:0] code = wdat_q[`SICU_CODE_MSB:0];
   wire is_imm = wr_q && (code <= `SICU_IMM_LAST);
   wire is_int = wr_q && (code >= `SICU_INT_FIRST) && (code <= `SICU_INT_LAST);
   wire is_init = (seq_in.role == ROLE_INIT);
   wire is_targ = (seq_in.role == ROLE_TARG);
   wire is_dis = (seq_in.role == ROLE_DIS);
   wire do_reset = is_imm && (code == `SICU_C_CHIP_RESET);
   wire do_disc = is_imm && (code == `SICU_C_DISCONNECT) && !is_dis;
   wire do_pause = is_imm && (code == `SICU_C_PAUSE) && !is_init;
   wire do_atn = is_imm && (code == `SICU_C_SET_ATN) && is_init;
   wire do_macc = is_imm && (code == `SICU_C_MSG_ACCEPT) && is_init;
   wire msgin_last = seq_in.last_in_byte && msgin_phase;

   // ************************************************************
   // Pause sequencing
   // ************************************************************
   sicu_pause_e pst_q;
   sicu_pause_e pst_d;
   logic [`SICU_HOLD_W-1:0] cnt_q;
   logic [`SICU_HOLD_W-1:0] cnt_d;
   logic ps_set;
   logic bus_set;
   logic abort_sel;

   always_comb begin
      pst_d = pst_q;
      cnt_d = cnt_q;
      ps_set = 1'b0;
      bus_set = 1'b0;
      abort_sel = 1'b0;
      unique case (pst_q)
         PS_IDLE: begin
            if (do_pause) begin
               if (is_targ && atn_on) begin
                  bus_set = 1'b1;
               end else if (is_targ && seq_in.xfer_active) begin
                  pst_d = PS_XFER;
               end else if (seq_in.sel_pending && seq_in.arb_won) begin
                  pst_d = PS_HOLD;
                  cnt_d = `SICU_HOLD_W'(SEL_HOLD_CYC - 1);
               end else begin
                  ps_set = 1'b1;
                  abort_sel = seq_in.sel_pending;
               end
            end
         end
         PS_XFER: begin
            // Counter is left alone so the same code can resume
            if (seq_in.intr_event) begin
               pst_d = PS_IDLE;
            end else if (seq_in.byte_done || !seq_in.xfer_active) begin
               ps_set = 1'b1;
               pst_d = PS_IDLE;
            end
         end
         PS_HOLD: begin
            if (seq_in.intr_event) begin
               pst_d = PS_IDLE;
            end else if (cnt_q == '0) begin
               pst_d = PS_BSY;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         PS_BSY: begin
            if (seq_in.intr_event) begin
               pst_d = PS_IDLE;
            end else if (!bsy_on) begin
               ps_set = 1'b1;
               abort_sel = 1'b1;
               pst_d = PS_IDLE;
            end
         end
      endcase
      // A pending interrupt wins over the paused flag
      if (seq_in.intr_event) begin
         ps_set = 1'b0;
      end
      if (do_reset || do_disc) begin
         pst_d = PS_IDLE;
      end
   end

   wire hold_sel = (pst_d == PS_HOLD) || (pst_d == PS_BSY);

   // ************************************************************
   // Status, command register and bus line state
   // ************************************************************
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic ps_q;
   logic ps_d;
   logic fnc_q;
   logic fnc_d;
   logic bsrv_q;
   logic bsrv_d;
   logic atn_q;
   logic atn_d;
   logic ackh_q;
   logic ackh_d;
   logic rel_q;
   logic rel_d;
   logic ign_q;
   logic ign_d;
   sicu_pins_s pins_d;
   sicu_ctl_s ctl_d;
   logic [7:0] asr_d;
   logic [7:0] ir_d;

   wire intr_any = msgin_last || bus_set || seq_in.intr_event;

   always_comb begin
      cmd_d = cmd_q;
      if (intr_any) begin
         cmd_d = `SICU_CMD_RST_VAL;
      end
      if (is_int) begin
         cmd_d = wdat_q;
      end
      // Set wins over the clear from a read or a new command
      ps_d = ps_set || (ps_q && !wr_q);
      fnc_d = msgin_last || (fnc_q && !ir_rd_in);
      bsrv_d = bus_set || (bsrv_q && !ir_rd_in);
      ackh_d = msgin_last || (ackh_q && !do_macc);
      if (do_atn || seq_in.selatn_won || (seq_in.parity_err && seq_in.xfer_active)) begin
         atn_d = 1'b1;
      end else if (seq_in.msg_out_phase && (seq_in.tc_zero || seq_in.sbt_byte_done)) begin
         atn_d = 1'b0;
      end else begin
         atn_d = atn_q;
      end
      rel_d = do_disc || (rel_q && !(is_dis && !seq_in.sel_pending));
      if (do_disc && is_init && seq_in.timeout_disc) begin
         ign_d = 1'b1;
      end else if (is_int) begin
         ign_d = 1'b0;
      end else begin
         ign_d = ign_q;
      end
      if (do_disc) begin
         atn_d = 1'b0;
         ackh_d = 1'b0;
      end
      // Released lines stay released until disconnected with no selection pending, a late set cannot drive them
      pins_d.atn = atn_d && !rel_d;
      pins_d.ack = (seq_in.ack_req || ackh_d) && !rel_d;
      pins_d.sel = (seq_in.sel_req || hold_sel) && !rel_d;
      pins_d.id = (hold_sel || rel_d) ? `SICU_ID_OFF : seq_in.id_req;
      ctl_d.int_go = is_int;
      ctl_d.chip_reset = do_reset;
      ctl_d.disconnect = do_disc;
      ctl_d.abort_xfer = (pst_d == PS_XFER);
      ctl_d.abort_sel = abort_sel;
      ctl_d.ignore_target = ign_d;
      // Chip reset returns everything to its power-up state
      if (do_reset) begin
         cmd_d = `SICU_CMD_RST_VAL;
         ps_d = 1'b0;
         fnc_d = 1'b0;
         bsrv_d = 1'b0;
         atn_d = 1'b0;
         ackh_d = 1'b0;
         rel_d = 1'b0;
         ign_d = 1'b0;
         pins_d = '0;
         ctl_d = '0;
         ctl_d.chip_reset = 1'b1;
      end
   end

   // Status words: flag bits only, the rest reads as zero
   always_comb begin
      asr_d = `SICU_STAT_RST_VAL;
      asr_d[`SICU_ASR_PS_BIT] = ps_d;
      ir_d = `SICU_STAT_RST_VAL;
      ir_d[`SICU_IR_FNC_BIT] = fnc_d;
      ir_d[`SICU_IR_BUS_BIT] = bsrv_d;
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pst_q <= PS_IDLE;
         cnt_q <= '0;
         cmd_q <= `SICU_CMD_RST_VAL;
         ps_q <= 1'b0;
         fnc_q <= 1'b0;
         bsrv_q <= 1'b0;
         atn_q <= 1'b0;
         ackh_q <= 1'b0;
         rel_q <= 1'b0;
         ign_q <= 1'b0;
      end else begin
         pst_q <= pst_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         ps_q <= ps_d;
         fnc_q <= fnc_d;
         bsrv_q <= bsrv_d;
         atn_q <= atn_d;
         ackh_q <= ackh_d;
         rel_q <= rel_d;
         ign_q <= ign_d;
      end
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         command_register_out <= `SICU_CMD_RST_VAL;
         auxiliary_status_register_out <= `SICU_STAT_RST_VAL;
         interrupt_register_out <= `SICU_STAT_RST_VAL;
         ctl_out <= '0;
         bus_oe_out <= '0;
         bus_n_out <= '1;
      end else begin
         command_register_out <= cmd_d;
         auxiliary_status_register_out <= asr_d;
         interrupt_register_out <= ir_d;
         ctl_out <= ctl_d;
         // Open drain: driven low only while enabled
         bus_oe_out <= pins_d;
         bus_n_out <= ~pins_d;
      end
   end

endmodule : sicu_cmd_unit

// File: dv/sicu_scsi_far.sv
`timescale 1ns/1ps
module sicu_scsi_far
   import sicu_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic [3:0] far_in,
   input wire sicu_pins_s dev_n_in,
   output logic [4:0] bus_n_out
);
   // ************************************************************
   // Far target: wired lines with pull-ups
   // ************************************************************
   logic [3:0] bsy_q;
   // Slow answer: busy stays 12 cycles into a selection
   wire bsy_on = !dev_n_in.sel && bsy_q != 4'hc;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bsy_q <= 4'h0;
      end else if (dev_n_in.sel) begin
         bsy_q <= 4'h0;
      end else if (bsy_on) begin
         bsy_q <= bsy_q + 4'h1;
      end
   end
   assign bus_n_out = {~far_in[3:1], ~bsy_on, dev_n_in.atn & ~far_in[0]};
endmodule : sicu_scsi_far

// File: dv/sicu_cmd_unit_sva.sv
`timescale 1ns/1ps
module sicu_cmd_unit_sva
   import sicu_pkg::*;
#(
   parameter int unsigned SEL_HOLD_CYC = 2000
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic cmd_wr_in,
   input wire logic [7:0] wdata_in,
   input wire sicu_seq_s seq_in,
   input wire logic [4:0] bus_n_in,
   input wire logic [7:0] command_register_out,
   input wire logic [7:0] auxiliary_status_register_out,
   input wire logic [7:0] interrupt_register_out,
   input wire sicu_ctl_s ctl_out,
   input wire sicu_pins_s bus_n_out,
   input wire sicu_pins_s bus_oe_out
);
   // ************************************************************
   // Command effects at the ports
   // ************************************************************
   wire wr = cmd_wr_in;
   wire [4:0] cd = wdata_in[4:0];
   wire ini = seq_in.role == ROLE_INIT;
   wire dis = seq_in.role == ROLE_DIS;
   wire [7:0] auxiliary_status_register = auxiliary_status_register_out;
   default clocking dc @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   // Only the first 4 hold cycles are watched, so SEL_HOLD_CYC must be 3 or more
   sequence s_pause_arb; wr && cd == 5'h02 && dis && seq_in.sel_pending && seq_in.arb_won; endsequence
   sequence s_sel_hold; (bus_oe_out.sel && bus_oe_out.id == 2'b00 && !auxiliary_status_register[2]) [*4]; endsequence
   property p_sel_hold; s_pause_arb |-> ##2 s_sel_hold; endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select hold broken");
   // Length of the current select hold with both ID lines dropped, saturating
   logic [15:0] hold_cnt;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hold_cnt <= '0;
      end else if (bus_oe_out.sel && bus_oe_out.id == 2'b00) begin
         hold_cnt <= (hold_cnt == 16'hffff) ? hold_cnt : hold_cnt + 16'h0001;
      end else begin
         hold_cnt <= '0;
      end
   end
   property p_sel_full; $rose(auxiliary_status_register[2]) && $fell(bus_oe_out.sel) |-> hold_cnt >= SEL_HOLD_CYC; endproperty
   a_sel_full: assert property (p_sel_full) else $error("select hold too short");
   property p_atn_set; wr && cd == 5'h03 && ini |-> ##2 bus_oe_out.atn && !bus_n_out.atn; endproperty
   a_atn_set: assert property (p_atn_set) else $error("attention not set");
   property p_atn_clr; ini && seq_in.msg_out_phase && seq_in.tc_zero && !wr && !$past(cmd_wr_in)
      && !seq_in.selatn_won && !seq_in.parity_err |-> ##[1:2] !bus_oe_out.atn; endproperty
   a_atn_clr: assert property (p_atn_clr) else $error("attention not cleared");
   property p_disc; wr && cd == 5'h01 && !dis |-> ##2 ctl_out.disconnect && bus_oe_out == '0; endproperty
   a_disc: assert property (p_disc) else $error("disconnect failed");
   property p_int; wr && cd inside {[5'h08:5'h15]} |-> ##2 ctl_out.int_go
      && command_register_out == $past(wdata_in, 2); endproperty
   a_int: assert property (p_int) else $error("interrupt command not taken");
   property p_pause_idle; wr && cd == 5'h02 && dis && !seq_in.sel_pending |-> ##2 auxiliary_status_register[2]; endproperty
   a_pause_idle: assert property (p_pause_idle) else $error("idle pause flag missing");
   property p_pause_atn; wr && cd == 5'h02 && seq_in.role == ROLE_TARG && !bus_n_in[0]
      && !$past(bus_n_in[0], 4) |-> ##2 interrupt_register_out[1] && !auxiliary_status_register[2]; endproperty
   a_pause_atn: assert property (p_pause_atn) else $error("pause with attention wrong");
   property p_xfer; ctl_out.abort_xfer && seq_in.byte_done && !seq_in.intr_event |-> ##[1:2] auxiliary_status_register[2]; endproperty
   a_xfer: assert property (p_xfer) else $error("transfer pause flag missing");
   property p_msg_in; ini && seq_in.last_in_byte && bus_n_in[4:2] == 3'b000 && $past(bus_n_in[4:2], 4) == 3'b000
      |=> interrupt_register_out[0] && bus_oe_out.ack; endproperty
   a_msg_in: assert property (p_msg_in) else $error("last message byte wrong");
   property p_chip_reset; wr && cd == 5'h00 |-> ##2 ctl_out.chip_reset && command_register_out == 8'h00
      && auxiliary_status_register == 8'h00 && bus_oe_out == '0; endproperty
   a_chip_reset: assert property (p_chip_reset) else $error("chip reset incomplete");
endmodule : sicu_cmd_unit_sva

bind sicu_cmd_unit sicu_cmd_unit_sva #(.SEL_HOLD_CYC(SEL_HOLD_CYC)) chk_u (
   .clock_in(clock_in), .nrst_in(nrst_in), .cmd_wr_in(cmd_wr_in), .wdata_in(wdata_in),
   .seq_in(seq_in), .bus_n_in(bus_n_in), .command_register_out(command_register_out),
   .auxiliary_status_register_out(auxiliary_status_register_out),
   .interrupt_register_out(interrupt_register_out), .ctl_out(ctl_out),
   .bus_n_out(bus_n_out), .bus_oe_out(bus_oe_out)
);

// File: dv/sicu_cmd_unit_tb_top.sv
`timescale 1ns/1ps
module sicu_cmd_unit_tb_top;
   import sicu_pkg::*;
   logic clock_in, nrst_in, cmd_wr_in, ir_rd_in;
   logic [7:0] wdata_in, cr, auxiliary_status_register, ir;
   logic [4:0] bus_n_in;
   logic [3:0] far;
   sicu_seq_s seq;
   sicu_ctl_s ctl;
   sicu_pins_s pn, oe;
   int bad_count, tests_run;
   // ************************************************************
   // Design, far side and clock
   // ************************************************************
   sicu_cmd_unit #(.SEL_HOLD_CYC(4)) dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .cmd_wr_in(cmd_wr_in),
      .wdata_in(wdata_in), .ir_rd_in(ir_rd_in), .seq_in(seq), .bus_n_in(bus_n_in), .command_register_out(cr),
      .auxiliary_status_register_out(auxiliary_status_register), .interrupt_register_out(ir), .ctl_out(ctl), .bus_n_out(pn),
      .bus_oe_out(oe));
   sicu_scsi_far far_u (.clock_in(clock_in), .nrst_in(nrst_in), .far_in(far), .dev_n_in(pn), .bus_n_out(bus_n_in));
   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Returns in cycle 2 after the write edge
   task automatic wr(input logic [7:0] d);
      @(posedge clock_in);
      cmd_wr_in <= 1'b1;
      wdata_in <= d;
      @(posedge clock_in);
      cmd_wr_in <= 1'b0;
      @(posedge clock_in);
      #1;
   endtask : wr
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic poll(output int k);
      k = 0;
      while (!auxiliary_status_register[2] && k < 60) begin
         tick(1);
         k++;
      end
   endtask : poll
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_idle;
      seq.role <= ROLE_DIS;
      wr(8'h02);
      chk(auxiliary_status_register, 8'h04);
      wr(8'h01);
      chk(8'({ctl.disconnect, auxiliary_status_register[2]}), 8'h00);
      for (int c = 5; c < 8; c++) begin
         wr(8'(c));
         chk(cr, 8'h00);
      end
      seq.sel_pending <= 1'b1;
      wr(8'h02);
      chk({ctl.abort_sel, auxiliary_status_register[6:0]}, 8'h84);
      seq.sel_pending <= 1'b0;
   endtask : t_idle
   task automatic t_int;
      for (int c = 8; c < 22; c++) begin
         wr(8'(c));
         chk(8'({ctl.int_go, cr[4:0]}), 8'(c + 32));
         seq.intr_event <= 1'b1;
         @(posedge clock_in);
         seq.intr_event <= 1'b0;
         tick(1);
         chk(cr, 8'h00);
      end
   endtask : t_int
   task automatic t_atn;
      seq.role <= ROLE_INIT;
      wr(8'h03);
      chk(8'({oe.atn, pn.atn}), 8'h02);
      seq.msg_out_phase <= 1'b1;
      seq.tc_zero <= 1'b1;
      @(posedge clock_in);
      seq.tc_zero <= 1'b0;
      seq.msg_out_phase <= 1'b0;
      tick(2);
      chk(8'(oe.atn), 8'h00);
      seq.role <= ROLE_TARG;
      wr(8'h03);
      chk(8'(oe.atn), 8'h00);
   endtask : t_atn
   task automatic t_msgin;
      seq.role <= ROLE_INIT;
      far <= 4'he;
      repeat (6) @(posedge clock_in);
      seq.last_in_byte <= 1'b1;
      @(posedge clock_in);
      seq.last_in_byte <= 1'b0;
      #1;
      chk({oe.ack, ir[6:0]}, 8'h81);
      wr(8'h03);
      wr(8'h04);
      chk(8'({oe.atn, oe.ack}), 8'h02);
      wr(8'h01);
      chk(8'({ctl.disconnect, oe}), 8'h20);
      // Sequencer settles to disconnected, so the released lines may be used again
      seq.role <= ROLE_DIS;
      ir_rd_in <= 1'b1;
      @(posedge clock_in);
      ir_rd_in <= 1'b0;
      tick(1);
      chk(ir, 8'h00);
      far <= 4'h0;
   endtask : t_msgin
   task automatic t_targ;
      int k;
      seq.role <= ROLE_TARG;
      far <= 4'h1;
      tick(6);
      wr(8'h02);
      chk(8'({ir[1], auxiliary_status_register[2]}), 8'h02);
      far <= 4'h0;
      seq.xfer_active <= 1'b1;
      tick(6);
      wr(8'h02);
      chk(8'({ctl.abort_xfer, auxiliary_status_register[2]}), 8'h02);
      seq.byte_done <= 1'b1;
      @(posedge clock_in);
      seq.byte_done <= 1'b0;
      seq.xfer_active <= 1'b0;
      #1;
      poll(k);
      chk({k < 3, auxiliary_status_register[6:0]}, 8'h84);
   endtask : t_targ
   task automatic t_sel;
      int k;
      seq.role <= ROLE_DIS;
      seq.sel_pending <= 1'b1;
      seq.arb_won <= 1'b1;
      seq.id_req <= 2'h3;
      wr(8'h02);
      chk(8'({oe.sel, oe.id}), 8'h04);
      poll(k);
      // Far side holds busy 12 cycles, so the flag must wait for it
      chk(8'({k > 11, ctl.abort_sel}), 8'h03);
      seq <= '{role: ROLE_INIT, default: '0};
      wr(8'h03);
      wr(8'h00);
      chk(8'({ctl.chip_reset, oe}), 8'h20);
   endtask : t_sel
   task automatic t_misc;
      seq.selatn_won <= 1'b1;
      @(posedge clock_in);
      seq.selatn_won <= 1'b0;
      tick(1);
      chk(8'(oe.atn), 8'h01);
      seq.msg_out_phase <= 1'b1;
      seq.sbt_byte_done <= 1'b1;
      @(posedge clock_in);
      seq.msg_out_phase <= 1'b0;
      seq.sbt_byte_done <= 1'b0;
      tick(1);
      chk(8'(oe.atn), 8'h00);
      seq.xfer_active <= 1'b1;
      seq.parity_err <= 1'b1;
      @(posedge clock_in);
      seq.xfer_active <= 1'b0;
      seq.parity_err <= 1'b0;
      tick(1);
      chk(8'(oe.atn), 8'h01);
      seq.timeout_disc <= 1'b1;
      wr(8'h01);
      chk(8'({ctl.disconnect, ctl.ignore_target, oe.atn}), 8'h06);
      seq <= '0;
      wr(8'h08);
      chk(8'(ctl.ignore_target), 8'h00);
      seq.role <= ROLE_TARG;
      seq.xfer_active <= 1'b1;
      wr(8'h02);
      chk(8'(ctl.abort_xfer), 8'h01);
      seq.intr_event <= 1'b1;
      @(posedge clock_in);
      seq.intr_event <= 1'b0;
      seq.xfer_active <= 1'b0;
      tick(2);
      chk(8'({ctl.abort_xfer, auxiliary_status_register[2], cr[4:0]}), 8'h00);
   endtask : t_misc
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   initial begin
      nrst_in = 1'b0;
      cmd_wr_in = 1'b0;
      ir_rd_in = 1'b0;
      wdata_in = 8'h00;
      seq = '0;
      far = 4'h0;
      repeat (4) @(posedge clock_in);
      nrst_in <= 1'b1;
      t_idle();
      t_int();
      t_atn();
      t_msgin();
      t_targ();
      t_sel();
      t_misc();
      results();
   end
   initial begin
      #1000000;
      bad_count++;
      results();
   end
endmodule : sicu_cmd_unit_tb_top
